//--- hw/srs_check.sv
// running crc-16 and byte sum accumulator
module srs_check
    import srs_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic clr,
    input wire logic en,
    input wire logic [7:0] data,
    output logic [15:0] crc,
    output logic [7:0] sum
);
    logic [15:0] crc_r;
    logic [15:0] crc_nxt;
    logic [7:0] sum_r;
    logic [7:0] sum_nxt;

    always_comb
    begin
        crc_nxt = clr ? CRC_PRESET : crc_r; // RQ12
        sum_nxt = clr ? RST_BYTE : sum_r;
        if (en)
        begin
            crc_nxt = srs_crc_byte(crc_nxt, data); // RQ13 RQ14 RQ15
            sum_nxt = 8'(sum_nxt + data); // RQ11
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            crc_r <= CRC_PRESET;
            sum_r <= RST_BYTE;
        end
        else
        begin
            crc_r <= crc_nxt;
            sum_r <= sum_nxt;
        end
    end

    assign crc = crc_r;
    assign sum = sum_r;

    a_crc_preset: assert property (@(posedge clk) disable iff (!nrst) (clr && !en) |=> (crc == 16'hFFFF)) // RQ12
        else $error("crc not preset after clear");
endmodule // srs_check

//--- hw/srs_pkg.sv
// constants, carriers and helpers for the serial register slave
package srs_pkg;
    localparam logic [7:0] CH_COLON = 8'h3A;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [7:0] CH_DIGIT0 = 8'h30;
    localparam logic [7:0] CH_DIGIT9 = 8'h39;
    localparam logic [7:0] CH_LETTER_A = 8'h41;
    localparam logic [7:0] CH_LETTER_F = 8'h46;
    localparam logic [7:0] FN_READ = 8'h03;
    localparam logic [7:0] FN_WRITE = 8'h06;
    localparam logic [7:0] ADDR_GLOBAL = 8'h00;
    localparam logic [7:0] ADDR_IND_MAX = 8'hF0;
    localparam logic [7:0] ADDR_GRP_BASE = 8'hF0;
    localparam int GRP_SHIFT = 4;
    localparam logic [15:0] MAX_READ = 16'h000A;
    localparam logic [15:0] CRC_PRESET = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam int CRC_STEPS = 8;
    localparam logic [3:0] REQ_LEN_RTU = 4'h8;
    localparam logic [3:0] REQ_LEN_ASCII = 4'h7;
    localparam logic [3:0] RBUF_DEPTH = 4'h8;
    localparam int RDW_DEPTH = 10;
    localparam logic [4:0] RD_HDR_LEN = 5'h03;
    localparam logic [4:0] WR_REPLY_LEN = 5'h06;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;

    typedef enum logic [3:0] {
        S_IDLE, S_RX, S_CHECK, S_RDREQ, S_RDCAP, S_TXHEAD, S_TXBODY, S_TXCR, S_TXLF, S_TXEND
    } srs_state_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } srs_tx_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } srs_regreq_t;

    // one byte through the crc-16 accumulator
    function automatic logic [15:0] srs_crc_byte(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc ^ {8'h00, b};
        for (int i = 0; i < CRC_STEPS; i++)
        begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

    function automatic logic [7:0] srs_hex_char(input logic [3:0] nib);
        return (nib < 4'hA) ? (CH_DIGIT0 + {4'h0, nib}) : (CH_LETTER_A + {4'h0, nib - 4'hA});
    endfunction

    // bit 4 marks a legal hex character
    function automatic logic [4:0] srs_hex_val(input logic [7:0] ch);
        if (ch >= CH_DIGIT0 && ch <= CH_DIGIT9)
            return {1'b1, ch[3:0]};
        else if (ch >= CH_LETTER_A && ch <= CH_LETTER_F)
            return {1'b1, 4'(ch[3:0] + 4'h9)};
        else
            return 5'h00;
    endfunction

    // zero (global) when the own address is not an individual one
    function automatic logic [7:0] srs_group_addr(input logic [7:0] own);
        if (own == ADDR_GLOBAL || own > ADDR_IND_MAX)
            return ADDR_GLOBAL;
        else
            return ADDR_GRP_BASE + 8'((8'(own - 8'h01) >> GRP_SHIFT) + 8'h01);
    endfunction
endpackage

//--- hw/srs_slave.sv
// modbus slave frame handler for rtu and ascii framing
//
// Behaviour
// [RQ1] accept and answer frames in rtu or ascii framing, as selected
// [RQ2] ascii sends each byte as two hex characters, high nibble first
// [RQ3] ascii frames start with colon, end with cr lf; rtu has neither
// [RQ4] only function codes 03 and 06 are serviced
// [RQ5] read request: address, 03, start hi lo, count hi lo, check
// [RQ6] a read asks for at most ten registers
// [RQ7] broadcast reads are neither executed nor answered
// [RQ8] read reply: address, function, byte count, words high byte first, check
// [RQ9] 06 writes the 16-bit value and an individual request gets an echo
// [RQ10] broadcast 06 writes the register in every addressed slave
// [RQ11] lrc is the two's complement of the byte sum modulo 256
// [RQ12] crc accumulator is 16 bits, preset to all ones
// [RQ13] each byte is first xored into the accumulator low byte
// [RQ14] shift right with zero fill, xor A001 when a one drops out
// [RQ15] eight shift steps per byte; the final accumulator is the crc
// [RQ16] crc low byte is sent before the high byte
// [RQ17] group broadcast requests are executed without reply
// [RQ18] global broadcast requests are executed without reply
// [RQ19] address 0 global, 1 to 240 individual, 241 to 255 groups
// [RQ20] group n covers individual addresses 16(n-1)+1 to 16n
// [RQ21] bad check, foreign address or unknown function: drop silently
// [RQ22] behave as a slave on a shared multidrop link
module srs_slave
    import srs_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ascii_mode,
    input wire logic [7:0] own_addr,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_eof,
    output srs_tx_t tx,
    input wire logic tx_ready,
    output srs_regreq_t reg_req,
    input wire logic [15:0] reg_rd_data,
    output logic drop
);
    srs_state_t state_r, state_nxt;
    logic [3:0] rcnt_r, rcnt_nxt;
    logic ovf_r, ovf_nxt;
    logic nib_r, nib_nxt;
    logic [3:0] hin_r, hin_nxt;
    logic cr_r, cr_nxt;
    logic [3:0] ridx_r, ridx_nxt;
    logic [4:0] idx_r, idx_nxt;
    logic tnib_r, tnib_nxt;
    logic [4:0] tlen_r, tlen_nxt;
    srs_tx_t tx_r, tx_nxt;
    srs_regreq_t req_r, req_nxt;
    logic drop_r, drop_nxt;

    logic [7:0] rbuf [0:7];
    logic [15:0] rdw [0:RDW_DEPTH-1];

    logic rb_we;
    logic [7:0] rb_wd;
    logic rw_we;
    logic rx_clr, rx_en;
    logic [7:0] rx_byte;
    logic tk_clr, tk_en;
    logic [15:0] rx_crc, tk_crc;
    logic [7:0] rx_sum, tk_sum;
    logic [7:0] lrc;
    logic [7:0] grp;
    logic [7:0] fn;
    logic [15:0] sreg, val;
    logic hit_own, is_bcast, chk_ok, ld;
    logic [4:0] hv;
    logic [4:0] widx;
    logic [15:0] word;
    logic [7:0] body, cur;

    srs_check u_rx_check (
        .clk(clk),
        .nrst(nrst),
        .clr(rx_clr),
        .en(rx_en),
        .data(rx_byte),
        .crc(rx_crc),
        .sum(rx_sum)
    );

    srs_check u_tx_check (
        .clk(clk),
        .nrst(nrst),
        .clr(tk_clr),
        .en(tk_en),
        .data(body),
        .crc(tk_crc),
        .sum(tk_sum)
    );

    // request field decode
    always_comb
    begin
        fn = rbuf[1];
        sreg = {rbuf[2], rbuf[3]}; // RQ5
        val = {rbuf[4], rbuf[5]};
        grp = srs_group_addr(own_addr); // RQ19 RQ20
        hit_own = (rbuf[0] == own_addr) && (own_addr != ADDR_GLOBAL) && (own_addr <= ADDR_IND_MAX); // RQ19 RQ22
        is_bcast = (rbuf[0] == ADDR_GLOBAL) || (rbuf[0] == grp); // RQ17 RQ18
        if (ascii_mode)
            chk_ok = !ovf_r && (rcnt_r == REQ_LEN_ASCII) && (rx_sum == RST_BYTE); // RQ11
        else
            chk_ok = !ovf_r && (rcnt_r == REQ_LEN_RTU) && (rx_crc == RST_WORD); // RQ15
        lrc = 8'(8'h00 - tk_sum); // RQ11
        hv = srs_hex_val(rx_data); // RQ2
        ld = !tx_r.valid || tx_ready;
    end

    // reply byte selection
    always_comb
    begin
        widx = 5'(idx_r - RD_HDR_LEN);
        word = rdw[widx[4:1]];
        if (fn == FN_WRITE || idx_r < 5'h02)
            body = rbuf[idx_r[2:0]]; // RQ9
        else if (idx_r == 5'h02)
            body = {val[6:0], 1'b0}; // RQ8
        else
            body = widx[0] ? word[7:0] : word[15:8]; // RQ8
        if (idx_r < tlen_r)
            cur = body;
        else if (ascii_mode)
            cur = lrc;
        else if (idx_r == tlen_r)
            cur = tk_crc[7:0]; // RQ16
        else
            cur = tk_crc[15:8]; // RQ16
    end

    always_comb
    begin
        state_nxt = state_r;
        rcnt_nxt = rcnt_r;
        ovf_nxt = ovf_r;
        nib_nxt = nib_r;
        hin_nxt = hin_r;
        cr_nxt = cr_r;
        ridx_nxt = ridx_r;
        idx_nxt = idx_r;
        tnib_nxt = tnib_r;
        tlen_nxt = tlen_r;
        tx_nxt = tx_r;
        req_nxt = req_r;
        req_nxt.rd = 1'b0;
        req_nxt.wr = 1'b0;
        drop_nxt = 1'b0;
        rb_we = 1'b0;
        rb_wd = rx_data;
        rw_we = 1'b0;
        rx_clr = 1'b0;
        rx_en = 1'b0;
        rx_byte = rx_data;
        tk_clr = 1'b0;
        tk_en = 1'b0;
        case (state_r)
            S_IDLE:
            begin
                rcnt_nxt = 4'h0;
                ovf_nxt = 1'b0;
                nib_nxt = 1'b0;
                cr_nxt = 1'b0;
                if (rx_valid && ascii_mode && rx_data == CH_COLON) // RQ3
                begin
                    rx_clr = 1'b1;
                    state_nxt = S_RX;
                end
                else if (rx_valid && !ascii_mode) // RQ1
                begin
                    rx_clr = 1'b1;
                    rx_en = 1'b1;
                    rb_we = 1'b1;
                    rcnt_nxt = 4'h1;
                    state_nxt = S_RX;
                end
            end
            S_RX:
            begin
                if (ascii_mode)
                begin
                    if (rx_valid)
                    begin
                        if (rx_data == CH_COLON) // RQ3
                        begin
                            rx_clr = 1'b1;
                            rcnt_nxt = 4'h0;
                            ovf_nxt = 1'b0;
                            nib_nxt = 1'b0;
                            cr_nxt = 1'b0;
                        end
                        else if (cr_r)
                        begin
                            state_nxt = (rx_data == CH_LF) ? S_CHECK : S_IDLE; // RQ3
                            drop_nxt = (rx_data != CH_LF);
                        end
                        else if (rx_data == CH_CR && !nib_r)
                            cr_nxt = 1'b1;
                        else if (hv[4] && !nib_r)
                        begin
                            hin_nxt = hv[3:0]; // RQ2
                            nib_nxt = 1'b1;
                        end
                        else if (hv[4])
                        begin
                            rx_byte = {hin_r, hv[3:0]}; // RQ2
                            rb_wd = rx_byte;
                            rx_en = 1'b1;
                            nib_nxt = 1'b0;
                            rb_we = (rcnt_r != RBUF_DEPTH);
                            ovf_nxt = ovf_r || (rcnt_r == RBUF_DEPTH);
                            rcnt_nxt = (rcnt_r == RBUF_DEPTH) ? rcnt_r : 4'(rcnt_r + 4'h1);
                        end
                        else
                        begin
                            drop_nxt = 1'b1;
                            state_nxt = S_IDLE;
                        end
                    end
                end
                else if (rx_valid)
                begin
                    rx_en = 1'b1;
                    rb_we = (rcnt_r != RBUF_DEPTH);
                    ovf_nxt = ovf_r || (rcnt_r == RBUF_DEPTH);
                    rcnt_nxt = (rcnt_r == RBUF_DEPTH) ? rcnt_r : 4'(rcnt_r + 4'h1);
                end
                else if (rx_eof)
                    state_nxt = S_CHECK;
            end
            S_CHECK:
            begin
                state_nxt = S_IDLE;
                idx_nxt = 5'h00;
                tnib_nxt = 1'b0;
                ridx_nxt = 4'h0;
                if (!chk_ok || !(hit_own || is_bcast)) // RQ21
                    drop_nxt = 1'b1;
                else if (fn == FN_READ && !is_bcast && val != RST_WORD && val <= MAX_READ) // RQ4 RQ6 RQ7
                begin
                    tlen_nxt = 5'(RD_HDR_LEN + {val[3:0], 1'b0});
                    req_nxt.rd = 1'b1;
                    req_nxt.addr = sreg;
                    state_nxt = S_RDREQ;
                end
                else if (fn == FN_WRITE) // RQ4
                begin
                    req_nxt.wr = 1'b1; // RQ9 RQ10
                    req_nxt.addr = sreg;
                    req_nxt.wdata = val;
                    tlen_nxt = WR_REPLY_LEN;
                    state_nxt = is_bcast ? S_IDLE : S_TXHEAD; // RQ17 RQ18
                end
                else
                    drop_nxt = 1'b1; // RQ21
            end
            S_RDREQ:
            begin
                // rd pulse stands now, its data comes one cycle later
                state_nxt = S_RDCAP;
            end
            S_RDCAP:
            begin
                rw_we = 1'b1;
                ridx_nxt = 4'(ridx_r + 4'h1);
                if (ridx_nxt == val[3:0])
                    state_nxt = S_TXHEAD;
                else
                begin
                    req_nxt.rd = 1'b1;
                    req_nxt.addr = 16'(sreg + {12'h000, ridx_nxt});
                    state_nxt = S_RDREQ;
                end
            end
            S_TXHEAD:
            begin
                tk_clr = 1'b1;
                if (!ascii_mode)
                    state_nxt = S_TXBODY; // RQ3
                else if (ld)
                begin
                    tx_nxt = '{valid: 1'b1, data: CH_COLON}; // RQ3
                    state_nxt = S_TXBODY;
                end
            end
            S_TXBODY:
            begin
                if (ld && ascii_mode)
                begin
                    tx_nxt = '{valid: 1'b1, data: srs_hex_char(tnib_r ? cur[3:0] : cur[7:4])}; // RQ2
                    tnib_nxt = !tnib_r;
                    if (tnib_r)
                    begin
                        idx_nxt = 5'(idx_r + 5'h01);
                        tk_en = (idx_r < tlen_r);
                        if (idx_r == tlen_r)
                            state_nxt = S_TXCR;
                    end
                end
                else if (ld)
                begin
                    tx_nxt = '{valid: 1'b1, data: cur}; // RQ16
                    tk_en = (idx_r < tlen_r);
                    idx_nxt = 5'(idx_r + 5'h01);
                    if (idx_r == 5'(tlen_r + 5'h01))
                        state_nxt = S_TXEND;
                end
            end
            S_TXCR:
            begin
                if (ld)
                begin
                    tx_nxt = '{valid: 1'b1, data: CH_CR}; // RQ3
                    state_nxt = S_TXLF;
                end
            end
            S_TXLF:
            begin
                if (ld)
                begin
                    tx_nxt = '{valid: 1'b1, data: CH_LF}; // RQ3
                    state_nxt = S_TXEND;
                end
            end
            S_TXEND:
            begin
                if (ld)
                begin
                    tx_nxt.valid = 1'b0;
                    state_nxt = S_IDLE;
                end
            end
            default:
                state_nxt = S_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_r <= S_IDLE;
            rcnt_r <= 4'h0;
            ovf_r <= 1'b0;
            nib_r <= 1'b0;
            hin_r <= 4'h0;
            cr_r <= 1'b0;
            ridx_r <= 4'h0;
            idx_r <= 5'h00;
            tnib_r <= 1'b0;
            tlen_r <= 5'h00;
            tx_r <= '0;
            req_r <= '0;
            drop_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            rcnt_r <= rcnt_nxt;
            ovf_r <= ovf_nxt;
            nib_r <= nib_nxt;
            hin_r <= hin_nxt;
            cr_r <= cr_nxt;
            ridx_r <= ridx_nxt;
            idx_r <= idx_nxt;
            tnib_r <= tnib_nxt;
            tlen_r <= tlen_nxt;
            tx_r <= tx_nxt;
            req_r <= req_nxt;
            drop_r <= drop_nxt;
        end
    end

    // request bytes and read words
    always_ff @(posedge clk)
    begin
        if (rb_we)
            rbuf[rcnt_r[2:0]] <= rb_wd;
        if (rw_we)
            rdw[ridx_r] <= reg_rd_data;
    end

    assign tx = tx_r;
    assign reg_req = req_r;
    assign drop = drop_r;

    a_read_own_only: assert property (@(posedge clk) disable iff (!nrst) req_r.rd |-> (rbuf[0] == own_addr)) // RQ7
        else $error("register read on a broadcast address");
    a_write_value: assert property (@(posedge clk) disable iff (!nrst)
        req_r.wr |-> (req_r.wdata == {rbuf[4], rbuf[5]} && req_r.addr == {rbuf[2], rbuf[3]})) // RQ9
        else $error("written value differs from request");
    a_fn_supported: assert property (@(posedge clk) disable iff (!nrst)
        (req_r.rd || req_r.wr) |-> (rbuf[1] == 8'h03 || rbuf[1] == 8'h06)) // RQ4
        else $error("unsupported function executed");
    a_read_limit: assert property (@(posedge clk) disable iff (!nrst)
        req_r.rd |-> ({rbuf[4], rbuf[5]} >= 16'h0001 && {rbuf[4], rbuf[5]} <= 16'h000A)) // RQ6
        else $error("read count out of range");
    a_bcast_silent: assert property (@(posedge clk) disable iff (!nrst)
        (state_r == S_CHECK && $past(state_r) != S_CHECK && rbuf[0] != own_addr) |-> ##1 (state_r != S_TXHEAD)[*8]) // RQ17 RQ18
        else $error("reply to broadcast request");
    a_ascii_header: assert property (@(posedge clk) disable iff (!nrst)
        (state_r == S_TXHEAD && ascii_mode && ld) |=> (tx_r.valid && tx_r.data == 8'h3A)) // RQ3
        else $error("ascii reply without colon");
    a_ascii_trailer: assert property (@(posedge clk) disable iff (!nrst)
        (state_r == S_TXCR && ld) |=> (tx_r.data == 8'h0D) ##1 (tx_r.data == 8'h0D || tx_r.data == 8'h0A)) // RQ3
        else $error("ascii reply trailer wrong");
    a_hex_chars: assert property (@(posedge clk) disable iff (!nrst)
        (ascii_mode && state_r == S_TXBODY && ld)
        |=> ((tx_r.data >= 8'h30 && tx_r.data <= 8'h39) || (tx_r.data >= 8'h41 && tx_r.data <= 8'h46))) // RQ2
        else $error("non hex character in ascii body");
    a_drop_no_exec: assert property (@(posedge clk) disable iff (!nrst)
        drop_r |-> !(req_r.rd || req_r.wr) ##1 !(req_r.rd || req_r.wr)) // RQ21
        else $error("dropped frame executed");
endmodule // srs_slave

//--- verif/serial_register_slave_test.sv
// self-checking bench for the serial register slave
module serial_register_slave_test import srs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    typedef logic [7:0] srs_bytes_t[$];
    logic clk, nrst, ascii_mode, rx_valid, rx_eof, tx_ready, drop;
    logic [7:0] own_addr, rx_data;
    logic [15:0] reg_rd_data;
    srs_tx_t tx;
    srs_regreq_t reg_req;
    logic [15:0] mem[logic [15:0]];
    int fail_count, checks, cycles, drop_cnt, wr_cnt;
    srs_bytes_t none;

    srs_slave i_srs_slave (.clk(clk), .nrst(nrst), .ascii_mode(ascii_mode), .own_addr(own_addr),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_eof(rx_eof), .tx(tx), .tx_ready(tx_ready),
        .reg_req(reg_req), .reg_rd_data(reg_rd_data), .drop(drop));
    srs_master_model i_srs_master_model (.clk(clk), .nrst(nrst), .tx(tx), .tx_ready(tx_ready));

    always #50 clk = ~clk;

    function automatic logic [15:0] rdval(logic [15:0] a);
        return mem.exists(a) ? mem[a] : a ^ 16'h5A3C;
    endfunction

    function automatic logic [7:0] hexc(logic [3:0] n);
        return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
    endfunction

    // framed byte stream with lrc or crc appended
    function automatic srs_bytes_t wire_of(logic asc, srs_bytes_t b);
        srs_bytes_t w;
        logic [15:0] c;
        logic [7:0] s;
        c = 16'hFFFF;
        s = 8'h00;
        foreach (b[i])
        begin
            s = s + b[i];
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++)
                c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
        end
        if (asc)
        begin
            b.push_back(8'h00 - s);
            w.push_back(8'h3A);
            foreach (b[i])
            begin
                w.push_back(hexc(b[i][7:4]));
                w.push_back(hexc(b[i][3:0]));
            end
            w.push_back(8'h0D);
            w.push_back(8'h0A);
        end
        else
        begin
            w = b;
            w.push_back(c[7:0]);
            w.push_back(c[15:8]);
        end
        return w;
    endfunction

    function automatic srs_bytes_t mk(logic [7:0] ad, logic [7:0] fn, logic [15:0] x, logic [15:0] y);
        return '{ad, fn, x[15:8], x[7:0], y[15:8], y[7:0]};
    endfunction

    task automatic check(logic [31:0] got, logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic send(srs_bytes_t w);
        foreach (w[i])
        begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_data <= w[i];
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_eof <= !ascii_mode;
        @(posedge clk);
        rx_eof <= 1'b0;
    endtask

    task automatic txn(srs_bytes_t req, srs_bytes_t rsp, logic bad, int xd, int xw, logic [15:0] wa,
        logic [15:0] wd);
        int d0;
        int w0;
        srs_bytes_t exp;
        srs_bytes_t w;
        d0 = drop_cnt;
        w0 = wr_cnt;
        i_srs_master_model.got.delete();
        if (rsp.size() > 0)
            exp = wire_of(ascii_mode, rsp);
        w = wire_of(ascii_mode, req);
        if (bad)
            w[w.size() - 1 - 2 * ascii_mode] ^= 8'h01;
        send(w);
        for (int k = 0; k < 3000 && i_srs_master_model.got.size() < exp.size(); k++)
            @(posedge clk);
        repeat (40) @(posedge clk);
        check(i_srs_master_model.got.size(), exp.size());
        foreach (exp[i])
            if (i < i_srs_master_model.got.size())
                check(i_srs_master_model.got[i], exp[i]);
        check(drop_cnt - d0, xd);
        check(wr_cnt - w0, xw);
        if (xw > 0)
            check(mem[wa], wd);
    endtask

    // register store behind the request port, one cycle read latency
    always @(posedge clk)
    begin
        if (reg_req.rd === 1'b1)
            reg_rd_data <= rdval(reg_req.addr);
        if (reg_req.wr === 1'b1)
        begin
            mem[reg_req.addr] = reg_req.wdata;
            wr_cnt++;
        end
        if (drop === 1'b1)
            drop_cnt++;
        cycles++;
        if (cycles == 60000)
        begin
            fail_count++;
            end_of_test();
        end
    end

    initial
    begin
        logic [7:0] a;
        logic [7:0] g;
        logic [15:0] ra;
        logic [15:0] v;
        srs_bytes_t rsp;
        int n;
        clk = 1'b0;
        nrst = 1'b0;
        ascii_mode = 1'b0;
        own_addr = 8'h01;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_eof = 1'b0;
        reg_rd_data = 16'h0000;
        void'($urandom(10));
        repeat (6) @(posedge clk);
        check({tx.valid, reg_req.rd, reg_req.wr, drop}, 4'h0);
        nrst <= 1'b1;
        for (int m = 0; m < 3; m++)
        begin
            a = (m == 0) ? 8'h10 : (m == 1) ? 8'hF0 : 8'(2 + $urandom % 239);
            g = 8'hF0 + ((a - 8'h01) >> 4) + 8'h01;
            ascii_mode <= (m == 1);
            own_addr <= a;
            @(posedge clk);
            for (int r = 0; r < 3; r++)
            begin
                n = (r == 0) ? 1 : (r == 1) ? 10 : 2 + $urandom % 8;
                ra = 16'($urandom);
                rsp = '{a, FN_READ, 8'(2 * n)};
                for (int k = 0; k < n; k++)
                begin
                    v = rdval(ra + 16'(k));
                    rsp.push_back(v[15:8]);
                    rsp.push_back(v[7:0]);
                end
                txn(mk(a, FN_READ, ra, 16'(n)), rsp, 1'b0, 0, 0, 16'h0000, 16'h0000);
            end
            ra = 16'($urandom);
            v = 16'($urandom);
            txn(mk(a, FN_WRITE, ra, v), mk(a, FN_WRITE, ra, v), 1'b0, 0, 1, ra, v);
            v = ~v;
            txn(mk(g, FN_WRITE, ra, v), none, 1'b0, 0, 1, ra, v);
            v = v + 16'h1111;
            txn(mk(8'h00, FN_WRITE, ra, v), none, 1'b0, 0, 1, ra, v);
            txn(mk(8'h00, FN_READ, ra, 16'h0001), none, 1'b0, 1, 0, ra, v);
            txn(mk(g, FN_READ, ra, 16'h0001), none, 1'b0, 1, 0, ra, v);
            txn(mk(a, FN_READ, ra, 16'h0000), none, 1'b0, 1, 0, ra, v);
            txn(mk(a, FN_READ, ra, 16'h000B), none, 1'b0, 1, 0, ra, v);
            txn(mk(a, 8'h04, ra, 16'h0001), none, 1'b0, 1, 0, ra, v);
            txn(mk(a ^ 8'h01, FN_WRITE, ra, 16'h0000), none, 1'b0, 1, 0, ra, v);
            txn(mk(g ^ 8'h01, FN_WRITE, ra, 16'h0000), none, 1'b0, 1, 0, ra, v);
            txn(mk(a, FN_WRITE, ra, 16'h0000), none, 1'b1, 1, 0, ra, v);
        end
        end_of_test();
    end
endmodule // serial_register_slave_test

//--- verif/srs_master_model.sv
// transmit-side partner: accepts reply bytes with random stalls and keeps them
module srs_master_model
    import srs_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire srs_tx_t tx,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got[$];
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            tx_ready <= 1'b0;
        else
        begin
            if (tx.valid && tx_ready)
                got.push_back(tx.data);
            tx_ready <= ($urandom % 3) != 0;
        end
    end
endmodule // srs_master_model
